// file: dv/bbf_core_assertions.sv
// Checker for the bus, irq and data link ports of the status block.
// Assumes binding to bbf_core; enables are shadowed from bus writes.
`timescale 1ns/100ps
`default_nettype none
module bbf_core_assertions #(
  parameter int WIN_COUNT = 23
) (
  input wire logic clk, // Master clock
  input wire logic rst_n, // Async reset
  input wire logic [9:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic tx_clk, // Line clock pin
  input wire logic tx_dl_bit, // Data link bit out
  input wire logic tx_dl_req, // Next bit taken
  input wire logic irq_out // Interrupt request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [5:0] en_r; // Both enable registers
  logic [4:0] idle_r; // Cycles since the line clock moved
  logic seen_r; // Line clock level last cycle
  logic [7:0] idx; // Register index
  assign idx = avs_address[9:2];
  // Enables change at the completing edge, as in the block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= 6'h00;
    end else if (avs_write && !avs_waitrequest) begin
      if (idx == 8'h3B) en_r[3:0] <= avs_writedata[3:0];
      if (idx == 8'h39) en_r[5:4] <= avs_writedata[1:0];
    end
  end
  // Saturates so that a long stop meets the check only once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 1'b0;
      idle_r <= 5'h00;
    end else begin
      seen_r <= tx_clk;
      if (tx_clk != seen_r) idle_r <= 5'h00;
      else if (idle_r != 5'h1F) idle_r <= idle_r + 5'h01;
    end
  end
  sequence s_stall;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_done;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  chk_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("stall without request");
  chk_wait_first: assert property ($rose(avs_read) || $rose(avs_write) |-> s_stall)
    else $error("new request not stalled");
  chk_wait_one: assert property (s_stall |=> s_done)
    else $error("stall longer than one cycle");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && !(idx inside
    {8'h38, 8'h39, 8'h3A, 8'h3B, 8'h40, 8'h41, 8'h42, 8'h43, 8'h50}) |-> avs_readdata == 0)
    else $error("unmapped read not zero");
  chk_rdata_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 0)
    else $error("read data above byte not zero");
  chk_irq_masked: assert property (en_r == 6'h00 |-> !irq_out)
    else $error("irq with all enables clear");
  chk_dl_hold: assert property (!$past(tx_dl_req) |-> $stable(tx_dl_bit))
    else $error("link bit moved without request");
  chk_lost_irq: assert property (idle_r == 5'h18 && en_r[0] |-> irq_out)
    else $error("stopped line clock gave no irq");
endmodule
bind bbf_core bbf_core_assertions #(.WIN_COUNT(WIN_COUNT)) chk (.clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .tx_clk,
  .tx_dl_bit, .tx_dl_req, .irq_out);
`default_nettype wire

// file: dv/bbf_far_end.sv
// Far-end model: line clock and data pin, receive data link and E1 streams.
// Assumes the bench clk; strobes move just after its rising edge.
`timescale 1ns/100ps
`default_nettype none
module bbf_far_end (
  input wire logic clk, // Master clock
  output logic tx_clk, // Line clock, 800 ns
  output logic tx_bit, // Outgoing data pin
  output logic rx_dl_bit, // Data link bit
  output logic rx_dl_valid, // Data link strobe
  output logic rx_e1_bit, // E1 bit
  output logic rx_e1_valid, // E1 strobe
  output logic rx_align_start // Align frame start
);
  logic run = 1'b1; // Line clock gate
  logic ones = 1'b1; // Data pin level
  // Line clock with phase unrelated to clk; holds its level while stopped
  initial begin
    {tx_clk, tx_bit, rx_dl_valid, rx_e1_valid, rx_align_start} = 5'h08;
    {rx_dl_bit, rx_e1_bit} = 2'h0;
    #37;
    forever #400 tx_clk = run ? ~tx_clk : tx_clk;
  end
  // Pin data moves on the falling line edge, clear of the sampling edge
  always @(negedge tx_clk) tx_bit <= ones;
  // Serial bits, top bit first; a released line shows the inverse
  task automatic send(input logic [15:0] w, input int n, input logic e1);
    if (e1) begin
      @(posedge clk);
      rx_align_start <= 1'b1;
      @(posedge clk);
      rx_align_start <= 1'b0;
    end
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      if (e1) {rx_e1_bit, rx_e1_valid} <= {w[i], 1'b1};
      else {rx_dl_bit, rx_dl_valid} <= {w[i], 1'b1};
      @(posedge clk);
      {rx_e1_bit, rx_dl_bit} <= ~{rx_e1_bit, rx_dl_bit};
      {rx_e1_valid, rx_dl_valid} <= 2'h0;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/test_bbf_core.sv
// Self-checking bench for the status and code block.
// Assumes the far-end model drives the line pins and receive streams.
`timescale 1ns/100ps
`default_nettype none
module test_bbf_core;
  logic clk, rst_n, avs_read, avs_write, framer_standard_select, tx_dl_req;
  logic avs_waitrequest, tx_clk, tx_bit, tx_dl_bit, irq_out;
  logic rx_dl_bit, rx_dl_valid, rx_align_start, rx_e1_bit, rx_e1_valid;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  bbf_pkg::bbf_tx_events_type tx_events;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  bbf_core dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .framer_standard_select, .tx_clk, .tx_bit, .tx_events,
    .rx_dl_bit, .rx_dl_valid, .tx_dl_bit, .tx_dl_req, .rx_align_start, .rx_e1_bit,
    .rx_e1_valid, .irq_out);
  bbf_far_end link (.clk, .tx_clk, .tx_bit, .rx_dl_bit, .rx_dl_valid, .rx_e1_bit,
    .rx_e1_valid, .rx_align_start);
  // 10 MHz master clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request held until waitrequest is low at a rising edge; data taken there
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
      output logic [7:0] q);
    @(posedge clk);
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h000000, d};
    {avs_write, avs_read} <= {w, ~w};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata[7:0];
    {avs_write, avs_read} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] i, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    chk(nm, {8'h00, exp}, {8'h00, q});
  endtask
  // Irq is combinational of registers: look once the edge has settled
  task automatic irq(input logic exp);
    @(negedge clk);
    chk("irq_out", {15'h0000, exp}, {15'h0000, irq_out});
  endtask
  function automatic logic [15:0] msg(input logic [5:0] c);
    return {8'hFF, 1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0};
  endfunction
  // Sixteen link bits, one request each, first bit at the top
  task automatic dl(input string nm, input logic [15:0] exp);
    logic [15:0] w;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      tx_dl_req <= 1'b1;
      @(posedge clk);
      tx_dl_req <= 1'b0;
      @(negedge clk);
      w = {w[14:0], tx_dl_bit};
    end
    chk(nm, exp, w);
  endtask
  task automatic ev(input logic [1:0] e);
    @(posedge clk);
    tx_events <= e;
    @(posedge clk);
    tx_events <= 2'b00;
  endtask
  task automatic t_regs();
    logic [7:0] map [9] = '{8'h3A, 8'h3B, 8'h38, 8'h39, 8'h40, 8'h41, 8'h42, 8'h43, 8'h50};
    foreach (map[i]) rd("reset value", map[i], 8'h00);
    wr(8'hFC, 8'hFF);
    rd("unmapped", 8'hFC, 8'h00);
    wr(8'h3B, 8'h0F);
    rd("irq enable", 8'h3B, 8'h0F);
    wr(8'h3B, 8'h00);
  endtask
  task automatic t_events();
    ev(2'b01);
    rd("multiframe ds1", 8'h3A, 8'h04);
    irq(1'b0);
    wr(8'h3B, 8'h04);
    irq(1'b1);
    wr(8'h3A, 8'h04);
    rd("cleared", 8'h3A, 8'h00);
    irq(1'b0);
    ev(2'b10);
    rd("align in ds1", 8'h3A, 8'h00);
    framer_standard_select <= 1'b1;
    ev(2'b10);
    rd("align e1", 8'h3A, 8'h08);
    ev(2'b01);
    rd("multiframe e1", 8'h3A, 8'h0C);
    wr(8'h3A, 8'h0C);
    wr(8'h3B, 8'h00);
    framer_standard_select <= 1'b0;
  endtask
  task automatic t_link();
    dl("idle flags", 16'h7E7E);
    wr(8'h43, 8'h2D);
    wr(8'h41, 8'h40);
    rd("send bit", 8'h41, 8'h40);
    dl("code message", msg(6'h2D));
    dl("code repeat", msg(6'h2D));
    wr(8'h41, 8'h00);
    dl("idle again", 16'h7E7E);
  endtask
  // Every filter and clear count; 7 of 10 gets a gap in its run
  task automatic t_rx();
    int need [5] = '{1, 3, 5, 7, 7};
    logic [5:0] c;
    logic [1:0] d;
    for (int f = 0; f < 5; f++) begin
      c = 6'h0B ^ 6'(f);
      d = f[1:0];
      wr(8'h40, 8'h00);
      wr(8'h40, {2'b10, d, f[2:0], 1'b0});
      wr(8'h38, 8'h03);
      for (int k = 1; k < need[f]; k++) begin
        if (f == 4 && k == 2) link.send(16'h7E7E, 16, 1'b0);
        link.send(msg(c), 16, 1'b0);
      end
      rd("code early", 8'h38, 8'h00);
      link.send(msg(c), 16, 1'b0);
      rd("code detected", 8'h38, 8'h01);
      rd("code value", 8'h42, {2'b00, c});
      repeat (d) link.send(16'h7E7E, 16, 1'b0);
      link.send(16'h7E7E, 15, 1'b0);
      rd("clear early", 8'h38, 8'h01);
      link.send(16'h0000, 1, 1'b0);
      rd("code cleared", 8'h38, 8'h03);
    end
    wr(8'h39, 8'h02);
    irq(1'b1);
    wr(8'h39, 8'h00);
    wr(8'h40, 8'h80);
    wr(8'h38, 8'h03);
    link.send(msg(6'h15), 16, 1'b0);
    rd("filter held", 8'h38, 8'h00);
  endtask
  task automatic t_e1();
    framer_standard_select <= 1'b1;
    link.send(16'h009B, 8, 1'b1);
    link.send(16'h0000, 8, 1'b1);
    rd("align capture", 8'h50, 8'h9B);
    framer_standard_select <= 1'b0;
  endtask
  task automatic t_clock();
    wr(8'h3B, 8'h03);
    link.run = 1'b0;
    repeat (30) @(posedge clk);
    rd("clock lost", 8'h3A, 8'h01);
    irq(1'b1);
    wr(8'h3A, 8'h01);
    link.run = 1'b1;
    repeat (40) @(posedge clk);
    rd("clock back", 8'h3A, 8'h02);
    wr(8'h3A, 8'h02);
    wr(8'h3B, 8'h08);
    link.ones = 1'b0;
    repeat (200) @(posedge clk);
    rd("density", 8'h3A, 8'h08);
    irq(1'b1);
  endtask
  // Reset, then the scenarios; receive control only touched in DS1
  initial begin
    {rst_n, avs_read, avs_write, framer_standard_select, tx_dl_req} = 5'h00;
    avs_address = 10'h000;
    avs_writedata = 32'h00000000;
    tx_events = 2'b00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_events();
    t_link();
    t_rx();
    t_e1();
    t_clock();
    end_of_test();
  end
endmodule
`default_nettype wire

// file: verilog/bbf_core.sv
// Transmit status flags, data link code receive/transmit and E1 align capture.
// Assumes framer strobes on clk; tx_clk and tx_bit arrive from the pin side.
`timescale 1ns/100ps
`default_nettype none
`include "bbf_map.svh"
module bbf_core #(
  parameter int WIN_COUNT = 23
) (
  input wire logic clk, // Master clock
  input wire logic rst_n, // Async reset
  input wire logic [9:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic framer_standard_select, // 0 DS1, 1 E1
  input wire logic tx_clk, // Transmit line clock pin
  input wire logic tx_bit, // Outgoing data bit pin
  input wire bbf_pkg::bbf_tx_events_type tx_events, // Transmit boundaries
  input wire logic rx_dl_bit, // Received data link bit
  input wire logic rx_dl_valid, // Strobe for rx_dl_bit
  output logic tx_dl_bit, // Data link bit to send
  input wire logic tx_dl_req, // Strobe: next bit taken
  input wire logic rx_align_start, // Start of align frame
  input wire logic rx_e1_bit, // Received E1 bit
  input wire logic rx_e1_valid, // Strobe for rx_e1_bit
  output logic irq_out // Interrupt request
);
  logic ack_r;
  logic [31:0] rdata_r;
  logic [7:0] idx;
  logic wr_en;
  logic [3:0] tx_status_r, tx_irq_en_r;
  logic [1:0] rx_status_r, rx_irq_en_r;
  logic [7:0] rx_ctrl_r, rx_value_r, align_cap_r;
  logic send_en_r;
  logic [5:0] tx_value_r;
  logic [3:0] set_tx;
  logic [1:0] set_rx;

  // Bus slave: one wait cycle; read data is latched at the stall edge, writes land one edge later
  assign idx = avs_address[9:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_en = avs_write & ack_r;
  assign avs_readdata = rdata_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // Read mux, unmapped words read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else if (avs_read && !ack_r) begin
      if (idx == `BBF_IDX_TX_STATUS) begin
        rdata_r <= {28'h0, tx_status_r};
      end else if (idx == `BBF_IDX_TX_IRQ_EN) begin
        rdata_r <= {28'h0, tx_irq_en_r};
      end else if (idx == `BBF_IDX_RX_STATUS) begin
        rdata_r <= {30'h0, rx_status_r};
      end else if (idx == `BBF_IDX_RX_IRQ_EN) begin
        rdata_r <= {30'h0, rx_irq_en_r};
      end else if (idx == `BBF_IDX_RX_CTRL) begin
        rdata_r <= {24'h0, rx_ctrl_r};
      end else if (idx == `BBF_IDX_TX_CTRL) begin
        rdata_r <= {25'h0, send_en_r, 6'h0};
      end else if (idx == `BBF_IDX_RX_VALUE) begin
        rdata_r <= {24'h0, rx_value_r};
      end else if (idx == `BBF_IDX_TX_VALUE) begin
        rdata_r <= {26'h0, tx_value_r};
      end else if (idx == `BBF_IDX_ALIGN_CAP) begin
        rdata_r <= {24'h0, align_cap_r};
      end else begin
        rdata_r <= 32'h0;
      end
    end
  end

  // Control registers; unused control bits read back zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_irq_en_r <= 4'h0;
      rx_irq_en_r <= 2'h0;
      rx_ctrl_r <= `BBF_RESET_BYTE;
      send_en_r <= 1'b0;
      tx_value_r <= 6'h0;
    end else if (wr_en) begin
      if (idx == `BBF_IDX_TX_IRQ_EN) begin
        tx_irq_en_r <= avs_writedata[3:0];
      end else if (idx == `BBF_IDX_RX_IRQ_EN) begin
        rx_irq_en_r <= avs_writedata[1:0];
      end else if (idx == `BBF_IDX_RX_CTRL) begin
        rx_ctrl_r <= avs_writedata[7:0] & 8'hBE;
      end else if (idx == `BBF_IDX_TX_CTRL) begin
        send_en_r <= avs_writedata[`BBF_TC_SEND];
      end else if (idx == `BBF_IDX_TX_VALUE) begin
        tx_value_r <= avs_writedata[5:0];
      end
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_status_r <= 4'h0;
      rx_status_r <= 2'h0;
    end else begin
      if (wr_en && idx == `BBF_IDX_TX_STATUS) begin
        tx_status_r <= (tx_status_r & ~avs_writedata[3:0]) | set_tx;
      end else begin
        tx_status_r <= tx_status_r | set_tx;
      end
      if (wr_en && idx == `BBF_IDX_RX_STATUS) begin
        rx_status_r <= (rx_status_r & ~avs_writedata[1:0]) | set_rx;
      end else begin
        rx_status_r <= rx_status_r | set_rx;
      end
    end
  end
  assign irq_out = |(tx_status_r & tx_irq_en_r) | |(rx_status_r & rx_irq_en_r);

  // Pin synchronisers and link clock edge detect
  logic [1:0] clk_sync_r, bit_sync_r;
  logic clk_prev_r, link_edge, link_rise;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sync_r <= 2'b00;
      bit_sync_r <= 2'b00;
      clk_prev_r <= 1'b0;
    end else begin
      clk_sync_r <= {clk_sync_r[0], tx_clk};
      bit_sync_r <= {bit_sync_r[0], tx_bit};
      clk_prev_r <= clk_sync_r[1];
    end
  end
  assign link_edge = clk_sync_r[1] ^ clk_prev_r;
  assign link_rise = clk_sync_r[1] & ~clk_prev_r;

  // Clock activity monitor; lost and restored fire once per change
  logic [4:0] idle_cnt_r, act_cnt_r;
  logic lost_r, set_lost, set_restored;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_r <= 5'h0;
      act_cnt_r <= 5'h0;
      lost_r <= 1'b0;
    end else begin
      // Keeps counting while lost so a lone glitch edge cannot pass for a running clock
      idle_cnt_r <= link_edge ? 5'h0 : (idle_cnt_r == 5'h1F) ? idle_cnt_r : idle_cnt_r + 5'h1;
      if (!lost_r) begin
        act_cnt_r <= 5'h0;
      end else if (idle_cnt_r > 5'h4) begin
        act_cnt_r <= 5'h0; // Gaps longer than a few cycles restart the count
      end else if (!set_restored) begin
        act_cnt_r <= act_cnt_r + 5'h1;
      end
      if (set_lost) begin
        lost_r <= 1'b1;
      end else if (set_restored) begin
        lost_r <= 1'b0;
      end
    end
  end
  assign set_lost = !lost_r && !link_edge && idle_cnt_r == `BBF_CLK_LOSS_CYCLES - 5'h1;
  assign set_restored = lost_r && act_cnt_r == `BBF_CLK_LOSS_CYCLES - 5'h1;

  // Density monitor: zero run and sliding one-count windows of 8*(n+1) bits
  logic [191:0] hist_r;
  logic [7:0] fill_r;
  logic [4:0] zrun_r;
  logic [WIN_COUNT:1] win_bad;
  logic density_bad;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_r <= 192'h0;
      fill_r <= 8'h0;
      zrun_r <= 5'h0;
    end else if (link_rise && !framer_standard_select) begin
      hist_r <= {hist_r[190:0], bit_sync_r[1]};
      fill_r <= (fill_r == `BBF_WIN_MAX) ? fill_r : fill_r + 8'h1;
      zrun_r <= bit_sync_r[1] ? 5'h0 : (zrun_r > `BBF_MAX_ZERO_RUN) ? zrun_r : zrun_r + 5'h1;
    end
  end
  genvar gi;
  generate
    for (gi = 1; gi <= WIN_COUNT; gi++) begin : g_win
      localparam logic [7:0] WLEN = 8'((gi + 1) * 8);
      logic [7:0] ones_r, ones_nxt;
      assign ones_nxt = ones_r + {7'h0, bit_sync_r[1]} - {7'h0, hist_r[WLEN - 1]};
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ones_r <= 8'h0;
        end else if (link_rise && !framer_standard_select) begin
          ones_r <= ones_nxt;
        end
      end
      // Checked only once the window is full of real bits
      assign win_bad[gi] = link_rise && fill_r >= WLEN - 8'h1 && ones_nxt < 8'(gi);
    end
  endgenerate
  assign density_bad = link_rise && !framer_standard_select &&
    ((!bit_sync_r[1] && zrun_r == `BBF_MAX_ZERO_RUN) || |win_bad);

  // Transmit flag sources by mode
  always_comb begin
    set_tx = 4'h0;
    set_tx[`BBF_TS_DENSITY] = framer_standard_select ? tx_events.align_start : density_bad;
    set_tx[`BBF_TS_MULTI] = tx_events.multi_start;
    set_tx[`BBF_TS_RESTORED] = set_restored;
    set_tx[`BBF_TS_LOST] = set_lost;
  end

  // Receive code: reset on rising control bit, fields latched then
  logic code_reset;
  logic [2:0] filt_r;
  logic [1:0] clr_sel_r;
  assign code_reset = wr_en && idx == `BBF_IDX_RX_CTRL &&
    avs_writedata[`BBF_RC_RESET] && !rx_ctrl_r[`BBF_RC_RESET];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_r <= 3'h0;
      clr_sel_r <= 2'h0;
    end else if (code_reset) begin
      filt_r <= avs_writedata[`BBF_RC_FILT_HI:`BBF_RC_FILT_LO];
      clr_sel_r <= avs_writedata[`BBF_RC_CLEAR_HI:`BBF_RC_CLEAR_LO];
    end
  end

  // Message framing on the received link: 11111111 0 d0..d5 0
  logic [15:0] rsh_r;
  logic [15:0] rsh_nxt;
  logic [4:0] gap_r;
  logic msg_match, msg_tick, msg_hit;
  logic [5:0] msg_code, cand_r;
  logic [3:0] run_r;
  logic [9:0] of10_r;
  logic [6:0] clr_cnt_r;
  logic qualified;
  bbf_pkg::bbf_rx_state_type rx_state_r;
  assign rsh_nxt = {rsh_r[14:0], rx_dl_bit};
  assign msg_match = rx_dl_valid && rsh_nxt[15:8] == `BBF_CODE_HEAD && !rsh_nxt[7] && !rsh_nxt[0];
  assign msg_code = {rsh_nxt[1], rsh_nxt[2], rsh_nxt[3], rsh_nxt[4], rsh_nxt[5], rsh_nxt[6]};
  assign msg_tick = msg_match || (rx_dl_valid && gap_r == `BBF_MSG_BITS - 5'h1);
  assign msg_hit = msg_match && msg_code == cand_r;

  // Count of ones in a 10-message history, used by the 7 of 10 filter
  function automatic logic [3:0] pop10(input logic [9:0] v);
    logic [3:0] s;
    s = 4'h0;
    for (int k = 0; k < 10; k++) begin
      s = s + {3'h0, v[k]};
    end
    return s;
  endfunction

  // Filter decision for the message just completed
  always_comb begin
    case (filt_r)
      `BBF_FILT_ONE: qualified = msg_match;
      `BBF_FILT_THREE: qualified = msg_hit && run_r >= 4'h2;
      `BBF_FILT_FIVE: qualified = msg_hit && run_r >= 4'h4;
      `BBF_FILT_SEVEN: qualified = msg_hit && run_r >= 4'h6;
      `BBF_FILT_7OF10: qualified = msg_hit && pop10({of10_r[8:0], 1'b1}) >= `BBF_OF10_NEED;
      default: qualified = 1'b0;
    endcase
  end

  // Framing shift and hit history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsh_r <= 16'h0;
      gap_r <= 5'h0;
      cand_r <= 6'h0;
      run_r <= 4'h0;
      of10_r <= 10'h0;
    end else if (code_reset) begin
      rsh_r <= 16'h0;
      gap_r <= 5'h0;
      run_r <= 4'h0;
      of10_r <= 10'h0;
    end else if (rx_dl_valid) begin
      rsh_r <= rsh_nxt;
      gap_r <= msg_tick ? 5'h0 : gap_r + 5'h1;
      if (msg_tick) begin
        of10_r <= {of10_r[8:0], msg_hit};
        if (msg_match && !msg_hit) begin
          cand_r <= msg_code;
          run_r <= 4'h1;
          of10_r <= 10'h001; // A new code counts as its own first occurrence
        end else if (msg_hit) begin
          run_r <= (run_r == 4'hF) ? run_r : run_r + 4'h1;
        end else begin
          run_r <= 4'h0;
        end
      end
    end
  end

  // Held code: cleared after the selected number of bits without it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_r <= bbf_pkg::BBF_SEARCH;
      rx_value_r <= `BBF_RESET_BYTE;
      clr_cnt_r <= 7'h0;
    end else if (code_reset) begin
      rx_state_r <= bbf_pkg::BBF_SEARCH;
      clr_cnt_r <= 7'h0;
    end else begin
      case (rx_state_r)
        bbf_pkg::BBF_SEARCH: begin
          if (qualified) begin
            rx_state_r <= bbf_pkg::BBF_HELD;
            rx_value_r <= {2'b00, msg_code};
            clr_cnt_r <= 7'h0;
          end
        end
        bbf_pkg::BBF_HELD: begin
          if (msg_match && msg_code == rx_value_r[5:0]) begin
            clr_cnt_r <= 7'h0;
          end else if (rx_dl_valid) begin
            clr_cnt_r <= clr_cnt_r + 7'h1;
            if (clr_cnt_r == {clr_sel_r, 4'hF} + 7'h10 * 7'(clr_sel_r) - 7'(clr_sel_r) * 7'h10) begin
              rx_state_r <= bbf_pkg::BBF_SEARCH;
            end
          end
        end
        default: rx_state_r <= bbf_pkg::BBF_SEARCH;
      endcase
    end
  end
  always_comb begin
    set_rx = 2'b00;
    set_rx[`BBF_RS_DETECTED] = rx_state_r == bbf_pkg::BBF_SEARCH && qualified && !code_reset;
    set_rx[`BBF_RS_CLEARED] = rx_state_r == bbf_pkg::BBF_HELD && !code_reset && rx_dl_valid &&
      !(msg_match && msg_code == rx_value_r[5:0]) &&
      clr_cnt_r == {clr_sel_r, 4'hF} + 7'h10 * 7'(clr_sel_r) - 7'(clr_sel_r) * 7'h10;
  end

  // Transmit link: code message or idle flags, loaded per message boundary
  logic [15:0] tx_msg_r;
  logic [3:0] tx_pos_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_msg_r <= `BBF_IDLE_MSG;
      tx_pos_r <= 4'h0;
      tx_dl_bit <= 1'b0;
    end else if (tx_dl_req) begin
      tx_pos_r <= tx_pos_r + 4'h1;
      if (tx_pos_r == 4'h0) begin
        tx_msg_r <= send_en_r ? {`BBF_CODE_HEAD, 1'b0, tx_value_r[0], tx_value_r[1], tx_value_r[2],
          tx_value_r[3], tx_value_r[4], tx_value_r[5], 1'b0} : `BBF_IDLE_MSG;
        tx_dl_bit <= send_en_r ? 1'b1 : 1'b0;
      end else begin
        tx_dl_bit <= tx_msg_r[4'hF - tx_pos_r];
      end
    end
  end

  // E1 align frame capture: eight bits after start, latched at next start
  logic [7:0] af_sh_r;
  logic [3:0] af_cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      af_sh_r <= 8'h0;
      af_cnt_r <= 4'h8;
      align_cap_r <= `BBF_RESET_BYTE;
    end else if (framer_standard_select && rx_align_start) begin
      align_cap_r <= af_sh_r;
      af_cnt_r <= 4'h0;
    end else if (rx_e1_valid && af_cnt_r < 4'h8) begin
      af_sh_r <= {af_sh_r[6:0], rx_e1_bit};
      af_cnt_r <= af_cnt_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: verilog/bbf_map.svh
// Register indices, field positions and counts of the status and code block.
// Assumes inclusion by bare name from the block's design files.
`ifndef BBF_MAP_SVH
`define BBF_MAP_SVH
`define BBF_IDX_TX_STATUS 8'h3A
`define BBF_IDX_TX_IRQ_EN 8'h3B
`define BBF_IDX_RX_STATUS 8'h38
`define BBF_IDX_RX_IRQ_EN 8'h39
`define BBF_IDX_RX_CTRL 8'h40
`define BBF_IDX_TX_CTRL 8'h41
`define BBF_IDX_RX_VALUE 8'h42
`define BBF_IDX_TX_VALUE 8'h43
`define BBF_IDX_ALIGN_CAP 8'h50
`define BBF_RESET_BYTE 8'h00
`define BBF_TS_DENSITY 3
`define BBF_TS_MULTI 2
`define BBF_TS_RESTORED 1
`define BBF_TS_LOST 0
`define BBF_RS_CLEARED 1
`define BBF_RS_DETECTED 0
`define BBF_RC_RESET 7
`define BBF_RC_CLEAR_HI 5
`define BBF_RC_CLEAR_LO 4
`define BBF_RC_FILT_HI 3
`define BBF_RC_FILT_LO 1
`define BBF_TC_SEND 6
`define BBF_CLK_LOSS_CYCLES 5'h0F
`define BBF_MAX_ZERO_RUN 5'h0F
`define BBF_WIN_MAX 8'hC0
`define BBF_MSG_BITS 5'h10
`define BBF_IDLE_MSG 16'h7E7E
`define BBF_CODE_HEAD 8'hFF
`define BBF_FILT_ONE 3'h0
`define BBF_FILT_THREE 3'h1
`define BBF_FILT_FIVE 3'h2
`define BBF_FILT_SEVEN 3'h3
`define BBF_FILT_7OF10 3'h4
`define BBF_OF10_NEED 4'h7
`endif

// file: verilog/bbf_pkg.sv
// Types shared by the status and code block.
// Assumes the map header supplies every number except the state codes.
package bbf_pkg;
  // Frame boundary strobes from the transmit framer, one clk cycle each
  typedef struct packed {
    logic align_start;
    logic multi_start;
  } bbf_tx_events_type;
  // Receive code qualifier state
  typedef enum logic [1:0] {
    BBF_SEARCH = 2'b01,
    BBF_HELD = 2'b10
  } bbf_rx_state_type;
endpackage
